// >>> scr_cfg.svh
// constants for the core clock source and adc rate block
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

`define SCR_IDX_RATE 6'h07
`define SCR_IDX_MODE 6'h0A
`define SCR_IDX_SRC 6'h0B
`define SCR_IDX_STAT 6'h0C

`define SCR_BIT_SRC_SEL 14
`define SCR_BIT_FORCE 13
`define SCR_BIT_PREDIV_HI 12
`define SCR_BIT_PREDIV_LO 11
`define SCR_BIT_INVERT 10
`define SCR_BIT_RATE_HI 7
`define SCR_BIT_RATE_LO 5
`define SCR_BIT_MODE 10

`define SCR_PREDIV_DIV2 2'h2

`define SCR_SRC_RST 16'h0000
`define SCR_RATE_RST 16'h0000
`define SCR_MODE_RST 16'h0000

`define SCR_FS_NORMAL 9'h100
`define SCR_FS_USB 9'h110

`define SCR_RESP_OKAY 2'h0
`define SCR_RESP_SLVERR 2'h2

`endif

// >>> scr_pkg.sv
// types for the core clock source and adc rate block
package scr_pkg;

	typedef enum logic [1:0] {SW_RUN, SW_WAIT_OLD_LOW, SW_WAIT_NEW_LOW} scr_sw_t;

	typedef struct packed {
		logic [15:0] src_ctrl;
		logic [15:0] rate_ctrl;
		logic [15:0] mode_ctrl;
	} scr_regs_t;

	typedef struct packed {
		logic aw_have;
		logic [5:0] aw_idx;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} scr_axi_t;

	typedef struct packed {
		scr_sw_t sw;
		logic act;
		logic mux_lvl;
		logic core;
	} scr_clk_t;

	typedef struct packed {
		scr_regs_t regs;
		scr_axi_t axi;
		scr_clk_t clk;
	} scr_state_t;

	typedef struct packed {
		logic [3:0] half;
		logic [8:0] fs;
		logic rate_en;
		logic fs_en;
	} scr_div_t;

endpackage

// >>> scr_ratediv.sv
// fractional adc rate divider and frame strobe from core clock half periods
`timescale 1ns/100ps
`include "scr_cfg.svh"

module scr_ratediv
	import scr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// core clock half-period tick
	input wire logic tick,
	// configuration
	input wire logic [2:0] code,
	input wire logic usb_mode,
	// strobes
	output logic rate_en,
	output logic fs_en
);

	scr_div_t st_r;
	scr_div_t st_nxt;
	logic [3:0] lim;
	logic [8:0] ratio;

	// half periods per output: /1.5 and /5.5 need odd half counts
	always_comb
	begin
		case (code)
			3'h0: lim = 4'h2;
			3'h1: lim = 4'h3;
			3'h2: lim = 4'h4;
			3'h3: lim = 4'h6;
			3'h4: lim = 4'h8;
			3'h5: lim = 4'hB;
			3'h6: lim = 4'hC;
			default: lim = 4'h0;
		endcase
	end

	assign ratio = usb_mode ? `SCR_FS_USB : `SCR_FS_NORMAL;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rate_en = 1'b0;
		st_nxt.fs_en = 1'b0;
		// reserved code stops the rate clock rather than guess a ratio
		if (tick && lim != 4'h0)
		begin
			if (st_r.half + 4'h1 >= lim)
			begin
				st_nxt.half = 4'h0;
				st_nxt.rate_en = 1'b1;
				if (st_r.fs + 9'h001 >= ratio)
				begin
					st_nxt.fs = 9'h000;
					st_nxt.fs_en = 1'b1;
				end
				else
				begin
					st_nxt.fs = st_r.fs + 9'h001;
				end
			end
			else
			begin
				st_nxt.half = st_r.half + 4'h1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign rate_en = st_r.rate_en;
	assign fs_en = st_r.fs_en;

endmodule

// >>> scr_top.sv
// core clock source selection, pre-divide, adc rate divider, axi4-lite registers
`timescale 1ns/100ps
`include "scr_cfg.svh"

module scr_top
	import scr_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	// axi4-lite write data
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// axi4-lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	// axi4-lite read data
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// clock sources, sampled levels
	input wire logic MASTER_CLOCK_IN,
	input wire logic PLL_CLOCK_IN,
	// toward the adc core
	output logic CORE_CLOCK,
	output logic ADC_RATE_EN,
	output logic ADC_FRAME_EN,
	output logic CLOCKING_MODE_SELECT
);

	scr_state_t st_r;
	scr_state_t st_nxt;
	logic master_clock;
	logic src_sel;
	logic force_sw;
	logic [1:0] prediv;
	logic old_lvl;
	logic new_lvl;
	logic mux_now;
	logic tick;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic [5:0] wr_idx;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [5:0] rd_idx;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0])
		begin
			r[7:0] = d[7:0];
		end
		if (s[1])
		begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	assign src_sel = st_r.regs.src_ctrl[`SCR_BIT_SRC_SEL];
	assign force_sw = st_r.regs.src_ctrl[`SCR_BIT_FORCE];
	assign prediv = st_r.regs.src_ctrl[`SCR_BIT_PREDIV_HI:`SCR_BIT_PREDIV_LO];

	// flipping this mid-stream can cut a pulse short
	assign master_clock = MASTER_CLOCK_IN ^ st_r.regs.src_ctrl[`SCR_BIT_INVERT];

	assign old_lvl = st_r.clk.act ? PLL_CLOCK_IN : master_clock;
	assign new_lvl = src_sel ? PLL_CLOCK_IN : master_clock;

	assign AWREADY = !st_r.axi.aw_have && !st_r.axi.bvalid;
	assign WREADY = !st_r.axi.w_have && !st_r.axi.bvalid;
	assign ARREADY = !st_r.axi.rvalid;
	assign aw_take = AWVALID && AWREADY;
	assign w_take = WVALID && WREADY;
	assign ar_take = ARVALID && ARREADY;
	assign wr_idx = aw_take ? AWADDR[7:2] : st_r.axi.aw_idx;
	assign wr_data = w_take ? WDATA : st_r.axi.wdata;
	assign wr_strb = w_take ? WSTRB : st_r.axi.wstrb;
	assign rd_idx = ARADDR[7:2];

	always_comb
	begin
		st_nxt = st_r;

		// switch sequencer: park low between the two sources
		case (st_r.clk.sw)
			SW_RUN:
			begin
				if (src_sel != st_r.clk.act)
				begin
					if (force_sw)
					begin
						// old source may be dead, so no low phase to wait for
						st_nxt.clk.act = src_sel;
					end
					else
					begin
						st_nxt.clk.sw = SW_WAIT_OLD_LOW;
					end
				end
			end
			SW_WAIT_OLD_LOW:
			begin
				// unless force is set, the high phase of the old source is never truncated
				// new must be high here, so the low that ends the next wait is a fresh fall
				if ((!old_lvl && new_lvl) || force_sw)
				begin
					st_nxt.clk.act = src_sel;
					st_nxt.clk.sw = SW_WAIT_NEW_LOW;
				end
			end
			SW_WAIT_NEW_LOW:
			begin
				// joining the new source only while it is low keeps its first high whole
				if (!new_lvl)
				begin
					st_nxt.clk.act = src_sel;
					st_nxt.clk.sw = SW_RUN;
				end
			end
			default:
			begin
				st_nxt.clk.sw = SW_RUN;
			end
		endcase

		if (st_r.clk.sw == SW_WAIT_NEW_LOW)
		begin
			mux_now = 1'b0;
		end
		else if (st_r.clk.sw == SW_WAIT_OLD_LOW && !old_lvl)
		begin
			mux_now = 1'b0;
		end
		else
		begin
			mux_now = old_lvl;
		end
		st_nxt.clk.mux_lvl = mux_now;

		// reserved pre-divide codes fall back to divide by one
		if (prediv == `SCR_PREDIV_DIV2)
		begin
			if (mux_now && !st_r.clk.mux_lvl)
			begin
				st_nxt.clk.core = !st_r.clk.core;
			end
		end
		else
		begin
			st_nxt.clk.core = mux_now;
		end

		// register bus: address and data may arrive in either order
		if (aw_take)
		begin
			st_nxt.axi.aw_have = 1'b1;
			st_nxt.axi.aw_idx = AWADDR[7:2];
		end
		if (w_take)
		begin
			st_nxt.axi.w_have = 1'b1;
			st_nxt.axi.wdata = WDATA;
			st_nxt.axi.wstrb = WSTRB;
		end
		if ((aw_take || st_r.axi.aw_have) && (w_take || st_r.axi.w_have))
		begin
			st_nxt.axi.aw_have = 1'b0;
			st_nxt.axi.w_have = 1'b0;
			st_nxt.axi.bvalid = 1'b1;
			st_nxt.axi.bresp = `SCR_RESP_OKAY;
			case (wr_idx)
				`SCR_IDX_SRC:
				begin
					st_nxt.regs.src_ctrl = merge16(st_r.regs.src_ctrl, wr_data, wr_strb);
				end
				`SCR_IDX_RATE:
				begin
					st_nxt.regs.rate_ctrl = merge16(st_r.regs.rate_ctrl, wr_data, wr_strb);
				end
				`SCR_IDX_MODE:
				begin
					st_nxt.regs.mode_ctrl = merge16(st_r.regs.mode_ctrl, wr_data, wr_strb);
				end
				`SCR_IDX_STAT:
				begin
					st_nxt.axi.bresp = `SCR_RESP_OKAY;
				end
				default:
				begin
					st_nxt.axi.bresp = `SCR_RESP_SLVERR;
				end
			endcase
		end
		if (st_r.axi.bvalid && BREADY)
		begin
			st_nxt.axi.bvalid = 1'b0;
		end

		if (ar_take)
		begin
			st_nxt.axi.rvalid = 1'b1;
			st_nxt.axi.rresp = `SCR_RESP_OKAY;
			st_nxt.axi.rdata = 32'h00000000;
			case (rd_idx)
				`SCR_IDX_SRC:
				begin
					st_nxt.axi.rdata[15:0] = st_r.regs.src_ctrl;
				end
				`SCR_IDX_RATE:
				begin
					st_nxt.axi.rdata[15:0] = st_r.regs.rate_ctrl;
				end
				`SCR_IDX_MODE:
				begin
					st_nxt.axi.rdata[15:0] = st_r.regs.mode_ctrl;
				end
				`SCR_IDX_STAT:
				begin
					st_nxt.axi.rdata[0] = st_r.clk.act;
					st_nxt.axi.rdata[1] = st_r.clk.sw != SW_RUN;
					st_nxt.axi.rdata[2] = st_r.clk.core;
				end
				default:
				begin
					st_nxt.axi.rresp = `SCR_RESP_SLVERR;
				end
			endcase
		end
		else if (st_r.axi.rvalid && RREADY)
		begin
			st_nxt.axi.rvalid = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			st_r <= '0;
			st_r.regs.src_ctrl <= `SCR_SRC_RST;
			st_r.regs.rate_ctrl <= `SCR_RATE_RST;
			st_r.regs.mode_ctrl <= `SCR_MODE_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// both core clock edges count, so half-integer ratios fall out exactly
	assign tick = st_nxt.clk.core ^ st_r.clk.core;

	scr_ratediv u_ratediv
	(
		.clk(REF_CLK),
		.rst(RST),
		.tick(tick),
		.code(st_r.regs.rate_ctrl[`SCR_BIT_RATE_HI:`SCR_BIT_RATE_LO]),
		.usb_mode(st_r.regs.mode_ctrl[`SCR_BIT_MODE]),
		.rate_en(ADC_RATE_EN),
		.fs_en(ADC_FRAME_EN)
	);

	assign CORE_CLOCK = st_r.clk.core;
	assign CLOCKING_MODE_SELECT = st_r.regs.mode_ctrl[`SCR_BIT_MODE];
	assign BVALID = st_r.axi.bvalid;
	assign BRESP = st_r.axi.bresp;
	assign RVALID = st_r.axi.rvalid;
	assign RDATA = st_r.axi.rdata;
	assign RRESP = st_r.axi.rresp;

endmodule

// >>> scr_src_model.sv
// master clock and pll clock sources, each of them stoppable
`timescale 1ns/100ps
module scr_src_model(
	input wire logic clk,
	input wire logic run_m,
	input wire logic run_p,
	output logic mclk,
	output logic pclk
);
	logic [3:0] cm_r;
	logic [3:0] cp_r;
	always_ff @(posedge clk)
	begin
		cm_r <= run_m ? (cm_r == 4'h7 ? 4'h0 : cm_r + 4'h1) : 4'h0;
		cp_r <= run_p ? (cp_r == 4'hB ? 4'h0 : cp_r + 4'h1) : 4'h0;
	end
	// stopped source rests low; restart begins with a full high phase
	assign mclk = run_m && cm_r < 4'h4;
	assign pclk = run_p && cp_r < 4'h6;
endmodule

// >>> scr_top_asserts.sv
// port checker for the clock source and adc rate block
`timescale 1ns/100ps
module scr_top_asserts(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic BVALID,
	input wire logic [1:0] BRESP,
	input wire logic BREADY,
	input wire logic RVALID,
	input wire logic [31:0] RDATA,
	input wire logic RREADY,
	input wire logic CORE_CLOCK,
	input wire logic ADC_RATE_EN,
	input wire logic ADC_FRAME_EN,
	input wire logic CLOCKING_MODE_SELECT
);
	logic [8:0] n_r;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// rate pulses since the last frame strobe
	always_ff @(posedge REF_CLK)
		if (RST || ADC_FRAME_EN)
			n_r <= 9'h000;
		else if (ADC_RATE_EN)
			n_r <= n_r + 9'h001;
	property p_rst_out;
		$fell(RST) |-> !CORE_CLOCK && !BVALID && !RVALID && !CLOCKING_MODE_SELECT;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
	// fastest source half period is four cycles
	property p_low_width;
		$fell(CORE_CLOCK) |=> !CORE_CLOCK [*3];
	endproperty
	a_low_width: assert property (p_low_width) else $error("core clock low too short");
	property p_rate_pulse;
		ADC_RATE_EN |=> !ADC_RATE_EN;
	endproperty
	a_rate_pulse: assert property (p_rate_pulse) else $error("rate strobe too long");
	property p_frame_count;
		ADC_FRAME_EN |-> n_r == 9'h0FF || n_r == 9'h10F;
	endproperty
	a_frame_count: assert property (p_frame_count) else $error("frame ratio wrong");
	property p_frame_on_rate;
		ADC_FRAME_EN |-> ADC_RATE_EN;
	endproperty
	a_frame_on_rate: assert property (p_frame_on_rate) else $error("frame off rate");
	property p_mode_write;
		$changed(CLOCKING_MODE_SELECT) |-> BVALID || $past(BVALID);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode moved unwritten");
	property p_bhold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold;
		RVALID && !RREADY |=> RVALID && $stable(RDATA);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind scr_top scr_top_asserts chk_u(.REF_CLK(REF_CLK), .RST(RST), .BVALID(BVALID),
	.BRESP(BRESP), .BREADY(BREADY), .RVALID(RVALID), .RDATA(RDATA), .RREADY(RREADY),
	.CORE_CLOCK(CORE_CLOCK), .ADC_RATE_EN(ADC_RATE_EN), .ADC_FRAME_EN(ADC_FRAME_EN),
	.CLOCKING_MODE_SELECT(CLOCKING_MODE_SELECT));

// >>> tb_top.sv
// self-checking bench for the clock source and adc rate block
`timescale 1ns/100ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] aw = 8'h00;
	logic [7:0] ar = 8'h00;
	logic [31:0] wd = 32'h00000000;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic bry = 1'b0;
	logic arv = 1'b0;
	logic rry = 1'b0;
	logic run_m = 1'b0;
	logic run_p = 1'b0;
	logic awr, wr_y, arr, bv, rv, mck, pck, core, rate, frame, mode;
	logic [1:0] br, rr;
	logic [31:0] rdt;
	int fail_count = 0;
	int check_count = 0;
	// rate pulses in 1056 cycles, core half period 4: 1056 / (4 * half count)
	int rc[8] = '{132, 88, 66, 44, 33, 24, 22, 0};
	scr_top dut_u(.REF_CLK(clk), .RST(rst), .AWADDR(aw), .AWVALID(awv), .AWREADY(awr),
		.WDATA(wd), .WSTRB(4'h3), .WVALID(wv), .WREADY(wr_y), .BRESP(br), .BVALID(bv),
		.BREADY(bry), .ARADDR(ar), .ARVALID(arv), .ARREADY(arr), .RDATA(rdt), .RRESP(rr),
		.RVALID(rv), .RREADY(rry), .MASTER_CLOCK_IN(mck), .PLL_CLOCK_IN(pck),
		.CORE_CLOCK(core), .ADC_RATE_EN(rate), .ADC_FRAME_EN(frame),
		.CLOCKING_MODE_SELECT(mode));
	scr_src_model src_u(.clk(clk), .run_m(run_m), .run_p(run_p), .mclk(mck), .pclk(pck));
	task automatic wrap_up;
		$display("checks %0d failures %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic do_reset;
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask
	// bready comes one edge late so the held response is seen
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
		aw <= a;
		wd <= {16'h0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr_y) wv <= 1'b0;
		end while ((awv && !awr) || (wv && !wr_y));
		@(posedge clk);
		bry <= 1'b1;
		do @(posedge clk); while (bv !== 1'b1);
		bry <= 1'b0;
		chk(br, e, "write resp");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		ar <= a;
		arv <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		@(posedge clk);
		rry <= 1'b1;
		do @(posedge clk); while (rv !== 1'b1);
		rry <= 1'b0;
		chk(rdt, e, "read data");
		chk(rr, er, "read resp");
	endtask
	task automatic cnt(input int w, input bit sel, input int e);
		int k;
		logic p;
		k = 0;
		p = core;
		repeat (w)
		begin
			@(posedge clk);
			k += sel ? int'(rate === 1'b1) : int'(core === 1'b1 && p === 1'b0);
			p = core;
		end
		chk(k, e, "edge count");
	endtask
	task automatic frame_len(input int e);
		int k;
		k = 0;
		do @(posedge clk); while (frame !== 1'b1);
		do
		begin
			@(posedge clk);
			k += int'(rate === 1'b1);
		end while (frame !== 1'b1);
		chk(k, e, "frame length");
	endtask
	initial forever #2.5 clk = ~clk;
	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		wrap_up;
	end
	initial
	begin
		do_reset;
		run_m <= 1'b1;
		rd(8'h1C, 32'h0, 2'h0);
		rd(8'h28, 32'h0, 2'h0);
		rd(8'h2C, 32'h0, 2'h0);
		rd(8'h3C, 32'h0, 2'h2);
		wr(8'h3C, 16'hFFFF, 2'h2);
		cnt(160, 0, 20);
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h1C, 16'(c << 5), 2'h0);
			repeat (64) @(posedge clk);
			cnt(1056, 1, rc[c]);
		end
		wr(8'h1C, 16'h0000, 2'h0);
		frame_len(256);
		// inversion only changes while the master clock is stopped
		run_m <= 1'b0;
		repeat (8) @(posedge clk);
		wr(8'h2C, 16'h0400, 2'h0);
		repeat (4) @(posedge clk);
		chk(core, 1, "inverted level");
		wr(8'h30, 16'hFFFF, 2'h0);
		rd(8'h30, 32'h00000004, 2'h0);
		wr(8'h2C, 16'h0000, 2'h0);
		repeat (4) @(posedge clk);
		chk(core, 0, "plain level");
		run_m <= 1'b1;
		run_p <= 1'b1;
		wr(8'h2C, 16'h4000, 2'h0);
		repeat (32) @(posedge clk);
		cnt(240, 0, 20);
		run_p <= 1'b0;
		repeat (8) @(posedge clk);
		wr(8'h2C, 16'h2000, 2'h0);
		repeat (32) @(posedge clk);
		cnt(160, 0, 20);
		wr(8'h2C, 16'h1000, 2'h0);
		rd(8'h2C, 32'h1000, 2'h0);
		repeat (32) @(posedge clk);
		cnt(160, 0, 10);
		do_reset;
		rd(8'h2C, 32'h0, 2'h0);
		wr(8'h28, 16'h0400, 2'h0);
		chk(mode, 1, "mode level");
		frame_len(272);
		wrap_up;
	end
endmodule
